// ==== hdl/serial_shift_pkg.sv ====
// Shared constants and carrier types for the serial shift port
package serial_shift_pkg;

  // ----------------------------------------------------------------
  // Widths and buffer sizing
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int SR_MSB = DATA_W - 1;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Mode field encodings (mode_field_high_bit .. mode_field_low_bit)
  // ----------------------------------------------------------------
  localparam int MODE_W = 3;
  localparam int MODE_HIGH_BIT = 2;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_IN_TIMER = 3'h1;
  localparam logic [2:0] MODE_IN_SYS = 3'h2;
  localparam logic [2:0] MODE_IN_EXT = 3'h3;
  localparam logic [2:0] MODE_FREE = 3'h4;
  localparam logic [2:0] MODE_OUT_TIMER = 3'h5;
  localparam logic [2:0] MODE_OUT_SYS = 3'h6;
  localparam logic [2:0] MODE_OUT_EXT = 3'h7;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_SYS = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [6:0] DIV_ZERO = 7'h00;
  localparam logic [6:0] DIV_STEP = 7'h01;
  localparam logic [6:0] DIV_SYS = 7'h02; // Three-cycle half bit under system-clock pacing
  localparam logic [7:0] SR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {phase_idle, phase_run} phase_e;

  // Drive of the two pins; enables are high while the block drives
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } pin_drive_s;

  typedef struct packed {
    phase_e phase;
    logic [7:0] sr;
    logic [3:0] bits;
    logic [6:0] div;
    logic done;
    logic push;
    logic [7:0] push_data;
    logic rx_valid;
    logic [7:0] rx_data;
    pin_drive_s pins;
    logic clk_s1;
    logic clk_s2;
    logic clk_prev;
    logic dat_s1;
    logic dat_s2;
  } shift_state_s;

endpackage

// ==== hdl/serial_shift_port.sv ====
// Serial shift port: 8-bit shift register with serial clock and data pins
module serial_shift_port (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [2:0] mode_in,
  input wire logic [7:0] timer_reload_in,
  input wire logic sr_write_in,
  input wire logic sr_read_in,
  input wire logic [7:0] wdata_in,
  input wire logic shift_clock_pin_in,
  input wire logic serial_data_pin_in,
  input wire logic rx_ready_in,
  output logic [7:0] rdata_out,
  output logic shift_done_out,
  output logic busy_out,
  output serial_shift_pkg::pin_drive_s pins_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);

  // ----------------------------------------------------------------
  // Mode decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_out(input logic [2:0] m);
    return m[serial_shift_pkg::MODE_HIGH_BIT];
  endfunction

  function automatic logic is_ext(input logic [2:0] m);
    return m[1:0] == serial_shift_pkg::SRC_EXT;
  endfunction

  function automatic logic is_shift_in(input logic [2:0] m);
    return !is_out(m) && (m != serial_shift_pkg::MODE_OFF);
  endfunction

  // Half bit time minus one; the timer gives at most 128 per half, 256 per bit
  // System pacing keeps three cycles a half: a sender answering our falls must clear the synchroniser
  function automatic logic [6:0] half_reload(input logic [2:0] m, input logic [7:0] r);
    if (m[1:0] == serial_shift_pkg::SRC_SYS) begin
      return serial_shift_pkg::DIV_SYS;
    end
    return r[7:1];
  endfunction

  function automatic logic [7:0] rotate(input logic [7:0] v);
    return {v[serial_shift_pkg::SR_MSB-1:0], v[serial_shift_pkg::SR_MSB]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  serial_shift_pkg::shift_state_s st;
  serial_shift_pkg::shift_state_s next_st;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;
  logic running;
  logic ext_fall;
  logic ext_rise;
  logic int_tick;
  logic fall;
  logic rise;
  logic access;
  logic last_rise;
  logic done_set;
  logic start_rd;
  logic start_wr;

  assign running = (st.phase == serial_shift_pkg::phase_run);
  assign access = sr_read_in | sr_write_in;
  // Edge detect looks only at the second and third sampling stages
  assign ext_fall = st.clk_prev & ~st.clk_s2;
  assign ext_rise = ~st.clk_prev & st.clk_s2;
  assign int_tick = running && !is_ext(mode_in) && (st.div == serial_shift_pkg::DIV_ZERO);
  assign fall = running && (is_ext(mode_in) ? ext_fall : (int_tick && st.pins.clk_o));
  assign rise = running && (is_ext(mode_in) ? ext_rise : (int_tick && !st.pins.clk_o));
  assign last_rise = rise && (st.bits == serial_shift_pkg::BIT_LAST);
  assign done_set = last_rise && (mode_in != serial_shift_pkg::MODE_FREE);
  // A read starts shift-in only while the receive buffer has room
  assign start_rd = sr_read_in && ((is_shift_in(mode_in) && fifo_in_ready) ||
                                   (mode_in == serial_shift_pkg::MODE_FREE));
  assign start_wr = sr_write_in && is_out(mode_in);
  assign fifo_out_ready = !st.rx_valid || rx_ready_in;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.push = 1'b0;
    // Two-stage sampling of both pins, third stage for edge detection
    next_st.clk_s1 = shift_clock_pin_in;
    next_st.clk_s2 = st.clk_s1;
    next_st.clk_prev = st.clk_s2;
    next_st.dat_s1 = serial_data_pin_in;
    next_st.dat_s2 = st.dat_s1;
    next_st.pins.dat_oe = is_out(mode_in);
    next_st.pins.clk_oe = (mode_in != serial_shift_pkg::MODE_OFF) && !is_ext(mode_in);
    // Internal shift clock divider; timer mode paces each half bit
    if (running && !is_ext(mode_in)) begin
      if (int_tick) begin
        next_st.div = half_reload(mode_in, timer_reload_in);
        next_st.pins.clk_o = ~st.pins.clk_o;
      end else begin
        next_st.div = st.div - serial_shift_pkg::DIV_STEP;
      end
    end
    // Data leaves on the falling edge and wraps into bit 0
    if (fall && is_out(mode_in)) begin
      next_st.pins.dat_o = st.sr[serial_shift_pkg::SR_MSB];
      next_st.sr = rotate(st.sr);
    end
    // Rising edge captures input and counts the bit
    if (rise) begin
      if (is_shift_in(mode_in)) begin
        next_st.sr = {st.sr[serial_shift_pkg::SR_MSB-1:0], st.dat_s2};
      end
      next_st.bits = st.bits + serial_shift_pkg::BIT_STEP;
      if (last_rise) begin
        next_st.bits = serial_shift_pkg::BIT_FIRST;
        if (mode_in != serial_shift_pkg::MODE_FREE) begin
          next_st.phase = serial_shift_pkg::phase_idle;
          next_st.push = is_shift_in(mode_in);
          next_st.push_data = {st.sr[serial_shift_pkg::SR_MSB-1:0], st.dat_s2};
        end
      end
    end
    // Processor access: write loads, either access may start an operation
    if (sr_write_in) begin
      next_st.sr = wdata_in;
    end
    if (start_wr || start_rd) begin
      next_st.phase = serial_shift_pkg::phase_run;
      next_st.bits = serial_shift_pkg::BIT_FIRST;
      next_st.div = half_reload(mode_in, timer_reload_in);
      next_st.pins.clk_o = 1'b1;
    end
    if (mode_in == serial_shift_pkg::MODE_OFF) begin
      next_st.phase = serial_shift_pkg::phase_idle;
      next_st.pins.clk_o = 1'b1;
    end
    // A completion in the same cycle as an access keeps the flag set
    next_st.done = done_set | (st.done & ~access);
    // Output stage in front of the user; stalls the buffer when held
    if (fifo_out_ready) begin
      next_st.rx_valid = fifo_out_valid;
      next_st.rx_data = fifo_out_data;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '{phase: serial_shift_pkg::phase_idle, sr: serial_shift_pkg::SR_RESET,
              bits: serial_shift_pkg::BIT_FIRST, div: serial_shift_pkg::DIV_ZERO,
              done: 1'b0, push: 1'b0, push_data: serial_shift_pkg::SR_RESET,
              rx_valid: 1'b0, rx_data: serial_shift_pkg::SR_RESET,
              pins: '{clk_o: 1'b1, clk_oe: 1'b0, dat_o: 1'b0, dat_oe: 1'b0},
              clk_s1: 1'b1, clk_s2: 1'b1, clk_prev: 1'b1, dat_s1: 1'b0, dat_s2: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // Room is checked when shift-in starts, not counting a push still pending, so a later push can be dropped
  shift_fifo #(
    .WIDTH(serial_shift_pkg::DATA_W),
    .DEPTH(serial_shift_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .in_valid_in(st.push),
    .in_data_in(st.push_data),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

  // Outputs straight from state flip-flops
  assign rdata_out = st.sr;
  assign shift_done_out = st.done;
  assign busy_out = running;
  assign pins_out = st.pins;
  assign rx_valid_out = st.rx_valid;
  assign rx_data_out = st.rx_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  logic [7:0] rotated;
  logic out_fall;
  logic quiet;
  assign rotated = rotate(st.sr);
  assign out_fall = fall && is_out(mode_in);
  assign quiet = !access && (mode_in != serial_shift_pkg::MODE_OFF);

  sequence s_free_run;
    running && (mode_in == serial_shift_pkg::MODE_FREE) && !sr_write_in ##1
      (mode_in == serial_shift_pkg::MODE_FREE);
  endsequence

  sequence s_last_bit;
    done_set && !access;
  endsequence

  property p_rotate;
    out_fall && !sr_write_in |=> st.sr == $past(rotated);
  endproperty
  a_rotate: assert property (p_rotate) else $error("shift-out did not rotate msb into lsb");

  property p_read_start;
    sr_read_in && !sr_write_in && (mode_in == serial_shift_pkg::MODE_IN_SYS) && fifo_in_ready
      |=> running && (st.bits == serial_shift_pkg::BIT_FIRST);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read did not start shift-in");

  property p_write_start;
    sr_write_in && is_out(mode_in) |=> running && (st.sr == $past(wdata_in));
  endproperty
  a_write_start: assert property (p_write_start) else $error("write did not load and start");

  property p_done;
    s_last_bit |=> st.done ##1 (st.done || $past(access));
  endproperty
  a_done: assert property (p_done) else $error("completion flag not raised");

  property p_free;
    s_free_run |-> running;
  endproperty
  a_free: assert property (p_free) else $error("free-running shift stopped");

  property p_pace;
    running && !is_ext(mode_in) && (st.div != serial_shift_pkg::DIV_ZERO) && quiet
      |=> $stable(st.pins.clk_o);
  endproperty
  a_pace: assert property (p_pace) else $error("shift clock toggled before pacing count ended");

  property p_data_edge;
    $changed(st.pins.dat_o) |-> $past(out_fall);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data pin changed without falling edge");

  property p_capture;
    rise && is_shift_in(mode_in) && !access |=> st.sr[0] == $past(st.dat_s2);
  endproperty
  a_capture: assert property (p_capture) else $error("input bit not captured on rising edge");

  property p_mode_off;
    mode_in == serial_shift_pkg::MODE_OFF |=> !running && !st.pins.clk_oe && !st.pins.dat_oe;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("disabled mode left port running");

  property p_stop_clear;
    (s_last_bit |=> !running && st.push == $past(is_shift_in(mode_in))) and
    (access && !done_set |=> !st.done);
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop after eight or flag clear failed");

  // A refused read must neither start nor leave the flag standing
  property p_refuse;
    sr_read_in && !sr_write_in && is_shift_in(mode_in) && !fifo_in_ready && !running
      |=> !running && !st.done;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read started shift-in with a full buffer");

  property p_enables;
    (mode_in != serial_shift_pkg::MODE_OFF) |=> (st.pins.clk_oe == $past(!is_ext(mode_in))) &&
      (st.pins.dat_oe == $past(is_out(mode_in)));
  endproperty
  a_enables: assert property (p_enables) else $error("pin enables do not follow the mode");

  property p_bit_range;
    running |-> st.bits <= serial_shift_pkg::BIT_LAST;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit count ran past eight");

  // Gathered bytes wait in the output stage until the user takes them
  property p_rx_hold;
    st.rx_valid && !rx_ready_in |=> st.rx_valid && $stable(st.rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received byte dropped before it was taken");

endmodule

// ==== hdl/shift_fifo.sv ====
// Parameterised valid/ready FIFO for received bytes
module shift_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_s;

  fifo_state_s st;
  fifo_state_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Full and empty come from the occupancy count, never from pointers alone
  assign in_ready_out = (st.count != (AW+1)'(DEPTH));
  assign out_valid_out = (st.count != '0);
  assign out_data_out = mem[st.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // State and storage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr] <= in_data_in;
    end
  end

endmodule

// ==== test/serial_shift_port_tb_top.sv ====
// Self-checking testbench for the serial shift port
module serial_shift_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [2:0] mode = 3'h0;
  logic [7:0] reload = 8'h04;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rx_ready = 1'b0;
  logic arm = 1'b0;
  logic gen = 1'b0;
  logic [7:0] ptx = 8'h00;
  logic [7:0] rdata;
  logic [7:0] rx_data;
  logic [7:0] p_rx;
  logic done;
  logic busy;
  logic rx_valid;
  logic p_sck;
  logic p_sda;
  logic sck;
  logic sda;
  serial_shift_pkg::pin_drive_s pins;
  int n_fail = 0;
  int n_checks = 0;
  // Wire levels: whoever enables wins, otherwise the partner
  assign sck = pins.clk_oe ? pins.clk_o : p_sck;
  assign sda = pins.dat_oe ? pins.dat_o : p_sda;
  always #12.5 clk_in = ~clk_in;
  serial_shift_port i_dut (.clk_in(clk_in), .srst_in(srst_in), .mode_in(mode), .timer_reload_in(reload),
    .sr_write_in(wr), .sr_read_in(rd), .wdata_in(wdata), .shift_clock_pin_in(sck), .serial_data_pin_in(sda),
    .rx_ready_in(rx_ready), .rdata_out(rdata), .shift_done_out(done), .busy_out(busy), .pins_out(pins),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data));
  shift_partner i_partner (.clk_gen_in(gen), .arm_in(arm), .tx_in(ptx), .sck_in(sck), .sda_in(sda),
    .sck_out(p_sck), .sda_out(p_sda), .rx_out(p_rx));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic access(input logic is_wr, input logic [7:0] d);
    @(posedge clk_in);
    wr <= is_wr;
    rd <= !is_wr;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Bounded wait for the end of an operation; a hang ends the run
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(negedge clk_in);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      $display("Error at %0t: operation never finished", $time);
      summarize();
    end
  endtask
  task automatic send_frame(input logic [7:0] b);
    @(posedge clk_in);
    ptx <= b;
    @(posedge clk_in);
    arm <= 1'b1;
    @(posedge clk_in);
    arm <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_shift_out;
    logic [7:0] pat [3];
    pat = '{8'h81, 8'h5C, 8'hE7};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_in);
      mode <= serial_shift_pkg::MODE_OUT_TIMER + 3'(i);
      gen <= (i == 2);
      access(1'b1, pat[i]);
      if (i == 2) send_frame(8'h00);
      wait_idle();
      chk(p_rx, pat[i], "byte at receiver");
      chk(rdata, pat[i], "register after eight shifts");
      chk({7'h00, done}, 8'h01, "completion flag");
    end
  endtask
  task automatic t_idle_mode;
    @(posedge clk_in);
    mode <= serial_shift_pkg::MODE_OFF;
    access(1'b0, 8'h00);
    @(negedge clk_in);
    chk({7'h00, done}, 8'h00, "flag after access");
    access(1'b1, 8'h3C);
    repeat (4) @(negedge clk_in);
    chk({7'h00, busy}, 8'h00, "busy when off");
    chk({6'h00, pins.clk_oe, pins.dat_oe}, 8'h00, "pin enables when off");
  endtask
  // Fill output stage and buffer (17 bytes) through all input modes, then drain
  task automatic t_shift_in;
    logic [7:0] q [$];
    logic [7:0] b;
    int k;
    int n;
    @(posedge clk_in);
    rx_ready <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      b = 8'(i * 29 + 90);
      @(posedge clk_in);
      mode <= serial_shift_pkg::MODE_IN_TIMER + 3'(i % 3);
      gen <= (i % 3 == 2);
      send_frame(b);
      access(1'b0, 8'h00);
      wait_idle();
      chk(rdata, b, "gathered byte");
      chk({7'h00, done}, 8'h01, "completion flag");
      q.push_back(b);
    end
    access(1'b0, 8'h00);
    repeat (3) @(negedge clk_in);
    chk({7'h00, busy}, 8'h00, "start with full buffer");
    chk({7'h00, done}, 8'h00, "flag after refused read");
    @(posedge clk_in);
    rx_ready <= 1'b1;
    k = 0;
    n = 0;
    while (k < 17 && n < 400) begin
      @(negedge clk_in);
      n++;
      if (rx_valid === 1'b1) begin
        chk(rx_data, q[k], "received byte order");
        k++;
      end
    end
    chk(8'(k), 8'h11, "bytes drained");
  endtask
  task automatic t_free_run;
    int c;
    int n;
    logic prev;
    @(posedge clk_in);
    mode <= serial_shift_pkg::MODE_FREE;
    reload <= 8'h0F;
    access(1'b1, 8'hAA);
    c = -1;
    n = 0;
    prev = 1'b0;
    while (n < 400) begin
      @(negedge clk_in);
      n++;
      if (c >= 0) c++;
      if (prev === 1'b1 && pins.clk_o === 1'b0) begin
        if (c > 0) break;
        c = 0;
      end
      prev = pins.clk_o;
    end
    chk(8'(c), 8'(2 * (int'(reload[7:1]) + 1)), "free-run bit time");
    repeat (300) @(negedge clk_in);
    chk({7'h00, busy}, 8'h01, "free-run still running");
    chk({7'h00, done}, 8'h00, "free-run sets no flag");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    t_shift_out();
    t_idle_mode();
    t_shift_in();
    t_free_run();
    summarize();
  end
endmodule

// ==== test/shift_partner.sv ====
// Far-side model: a plain shift register that sends and takes bytes MSB first
module shift_partner (
  input wire logic clk_gen_in,
  input wire logic arm_in,
  input wire logic [7:0] tx_in,
  input wire logic sck_in,
  input wire logic sda_in,
  output logic sck_out,
  output logic sda_out,
  output logic [7:0] rx_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh = 8'h00;
  int left = 0;
  initial begin
    sck_out = 1'b1;
    sda_out = 1'b0;
    rx_out = 8'h00;
  end
  // ----------------------------------------------------------------
  // Frame start; own clock idles high and runs only inside a frame
  // ----------------------------------------------------------------
  always @(posedge arm_in) begin
    sh = tx_in;
    left = 8;
    if (clk_gen_in) begin
      #5; // Pin edges stay clear of the system clock edge
      repeat (8) begin
        #100 sck_out = 1'b0;
        #100 sck_out = 1'b1;
      end
    end
  end
  // Bit goes out on the fall, a half period ahead of the rise
  always @(negedge sck_in) begin
    if (left > 0) begin
      sda_out = sh[7];
      sh = {sh[6:0], 1'b0};
      left--;
    end else begin
      sda_out = ~sda_out; // Released line must not look like held data
    end
  end
  // Receiver samples on the rising shift clock
  always @(posedge sck_in) rx_out = {rx_out[6:0], sda_in};
endmodule
